// [logic/buck_one_defines.vh]
// Purpose: offsets, fields, reset values and timing counts for buck one
// Assumes: 8-bit register port, 50 MHz core clock
// Notes: reset values apply until the fuse load pulse
`ifndef BUCK_ONE_DEFINES_VH
`define BUCK_ONE_DEFINES_VH
`define ADDR_RUN_VOLTAGE 8'h32
`define ADDR_STANDBY_VOLTAGE 8'h33
`define ADDR_SLEEP_VOLTAGE 8'h34
`define ADDR_CONTROL 8'h35
`define VOLT_MSB 5
`define VOLT_MASK 8'h3F
`define CTRL_MASK 8'h7F
`define BIT_RUN_EN 0
`define BIT_STANDBY_EN 1
`define BIT_SLEEP_EN 2
`define BIT_LOW_POWER 3
`define BIT_SCALE_RATE 4
`define BIT_FORCED_PWM_FALL 5
`define BIT_FORCED_PWM 6
`define RST_VOLT 6'h00
`define RST_CTRL 7'h00
`define STATE_RUN 2'd0
`define STATE_STANDBY 2'd1
`define STATE_SLEEP 2'd2
`define STEP_FAST_NS 2000
`define STEP_SLOW_NS 4000
`define CLK_PERIOD_NS 20
`define STEP_FAST_CYC (`STEP_FAST_NS / `CLK_PERIOD_NS)
`define STEP_SLOW_CYC (`STEP_SLOW_NS / `CLK_PERIOD_NS)
`endif

// [logic/buck_one_ramp.v]
// Purpose: steps the active voltage code toward its target
// Assumes: one code step per interval
// Notes: interval counts set by the caller
`timescale 1ns/1ns
`include "buck_one_defines.vh"
module buck_one_ramp #(
  parameter CW = 8
) (
  input wire core_clk_i,
  input wire rstn_i,
  input wire [5:0] target_i,
  input wire [CW-1:0] interval_i,
  input wire immediate_i,
  output reg [5:0] code_o,
  output reg falling_o
);
  reg [CW-1:0] cnt_reg;

  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_reg <= {CW{1'b0}};
      code_o <= `RST_VOLT;
      falling_o <= 1'b0;
    end else if (immediate_i) begin
      cnt_reg <= {CW{1'b0}};
      code_o <= target_i;
      falling_o <= 1'b0;
    end else if (code_o == target_i) begin
      cnt_reg <= {CW{1'b0}};
      falling_o <= 1'b0;
    end else if (cnt_reg >= interval_i - 1'b1) begin
      cnt_reg <= {CW{1'b0}};
      falling_o <= (code_o > target_i);
      if (code_o > target_i) begin
        code_o <= code_o - 6'd1;
      end else begin
        code_o <= code_o + 6'd1;
      end
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
      falling_o <= (code_o > target_i);
    end
  end
endmodule

// [logic/buck_one_mode_control_regs.v]
// Purpose: buck one run, standby, sleep voltage and control registers
// Assumes: synchronous register port and fuse load pulse
// Notes: all outputs registered
//
// Overview of operation
// - standby voltage code held, used in standby
// - sleep voltage code held, used in sleep
// - standby, sleep codes start at run code
// - fuse preloads voltage fields, host rewrites
// - bit 0 run enable, fuse loaded
// - bit 1 standby enable, starts as run
// - bit 2 sleep enable
// - zero enable turns buck off in mode
// - bit 3 low power in standby, sleep
// - bit 4 step every 2 or 4 us
// - rate bit ignored when fuse select set
// - bit 5 forced pwm while falling
// - bit 6 forced pwm always
// - voltage bits 7, 6 unused
// - run voltage code at 0x32
`timescale 1ns/1ns
`include "buck_one_defines.vh"
module buck_one_mode_control_regs #(
  parameter STEP_FAST = `STEP_FAST_CYC,
  parameter STEP_SLOW = `STEP_SLOW_CYC
) (
  input wire core_clk_i,
  input wire rstn_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire fuse_load_i,
  input wire [5:0] fuse_run_voltage_i,
  input wire fuse_run_enable_i,
  input wire fuse_scaling_rate_i,
  input wire fuse_buck_one_scaling_select_i,
  input wire [1:0] power_state_i,
  output reg [7:0] rdata_o,
  output reg rvalid_o,
  output reg buck_enable_o,
  output reg [5:0] buck_voltage_o,
  output reg buck_low_power_o,
  output reg buck_forced_pwm_o
);
  reg [5:0] buck_one_run_voltage_reg;
  reg [5:0] buck_one_standby_voltage_reg;
  reg [5:0] buck_one_sleep_voltage_reg;
  reg [6:0] buck_one_control_reg;
  reg [5:0] target_next;
  reg enable_next;
  reg [7:0] rdata_next;
  wire [5:0] ramp_code;
  wire ramp_falling;
  wire [7:0] step_interval;
  wire low_power_state;
  wire run_wr;
  wire standby_wr;
  wire sleep_wr;
  wire ctrl_wr;
  wire [5:0] ramp_target;
  reg rvalid_next;
  reg low_power_next;
  reg forced_pwm_next;

  function [7:0] read_mux;
    input [7:0] a;
    input [5:0] run_v;
    input [5:0] stby_v;
    input [5:0] slp_v;
    input [6:0] ctrl;
    begin
      case (a)
        `ADDR_RUN_VOLTAGE: read_mux = {2'b00, run_v};
        `ADDR_STANDBY_VOLTAGE: read_mux = {2'b00, stby_v};
        `ADDR_SLEEP_VOLTAGE: read_mux = {2'b00, slp_v};
        `ADDR_CONTROL: read_mux = {1'b0, ctrl};
        default: read_mux = 8'h00;
      endcase
    end
  endfunction

  function reg_write;
    input [7:0] a;
    input [7:0] sel;
    input w;
    input f;
    begin
      reg_write = w && !f && (a == sel);
    end
  endfunction

  function in_low_power_state;
    input [1:0] s;
    begin
      in_low_power_state = (s == `STATE_STANDBY) || (s == `STATE_SLEEP);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // write decode, fuse load wins
  // unmapped writes ignored
  assign run_wr = reg_write(addr_i, `ADDR_RUN_VOLTAGE, wr_i, fuse_load_i);
  assign standby_wr = reg_write(addr_i, `ADDR_STANDBY_VOLTAGE, wr_i, fuse_load_i);
  assign sleep_wr = reg_write(addr_i, `ADDR_SLEEP_VOLTAGE, wr_i, fuse_load_i);
  assign ctrl_wr = reg_write(addr_i, `ADDR_CONTROL, wr_i, fuse_load_i);

  ////////////////////////////////////////////////////////////////////
  // run voltage register
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      buck_one_run_voltage_reg <= `RST_VOLT;
    end else if (fuse_load_i) begin
      buck_one_run_voltage_reg <= fuse_run_voltage_i;
    end else if (run_wr) begin
      buck_one_run_voltage_reg <= wdata_i[`VOLT_MSB:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // standby voltage register
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      buck_one_standby_voltage_reg <= `RST_VOLT;
    end else if (fuse_load_i) begin
      buck_one_standby_voltage_reg <= fuse_run_voltage_i;
    end else if (standby_wr) begin
      buck_one_standby_voltage_reg <= wdata_i[`VOLT_MSB:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // sleep voltage register
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      buck_one_sleep_voltage_reg <= `RST_VOLT;
    end else if (fuse_load_i) begin
      buck_one_sleep_voltage_reg <= fuse_run_voltage_i;
    end else if (sleep_wr) begin
      buck_one_sleep_voltage_reg <= wdata_i[`VOLT_MSB:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // control register
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      buck_one_control_reg <= `RST_CTRL;
    end else if (fuse_load_i) begin
      buck_one_control_reg[`BIT_RUN_EN] <= fuse_run_enable_i;
      buck_one_control_reg[`BIT_STANDBY_EN] <= fuse_run_enable_i;
      buck_one_control_reg[`BIT_SCALE_RATE] <= fuse_scaling_rate_i;
    end else if (ctrl_wr) begin
      buck_one_control_reg <= wdata_i[6:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read data select
  always @* begin
    rdata_next = read_mux(addr_i, buck_one_run_voltage_reg, buck_one_standby_voltage_reg,
      buck_one_sleep_voltage_reg, buck_one_control_reg);
  end

  ////////////////////////////////////////////////////////////////////
  // voltage code select
  always @* begin
    target_next = buck_one_run_voltage_reg;
    case (power_state_i)
      `STATE_STANDBY: begin
        target_next = buck_one_standby_voltage_reg;
      end
      `STATE_SLEEP: begin
        target_next = buck_one_sleep_voltage_reg;
      end
      default: begin
        target_next = buck_one_run_voltage_reg;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // enable select
  always @* begin
    enable_next = buck_one_control_reg[`BIT_RUN_EN];
    case (power_state_i)
      `STATE_STANDBY: begin
        enable_next = buck_one_control_reg[`BIT_STANDBY_EN];
      end
      `STATE_SLEEP: begin
        enable_next = buck_one_control_reg[`BIT_SLEEP_EN];
      end
      default: begin
        enable_next = buck_one_control_reg[`BIT_RUN_EN];
      end
    endcase
  end

  assign low_power_state = in_low_power_state(power_state_i);
  assign ramp_target = fuse_load_i ? fuse_run_voltage_i : target_next;
  assign step_interval = (buck_one_control_reg[`BIT_SCALE_RATE] &&
    !fuse_buck_one_scaling_select_i) ? STEP_SLOW[7:0] : STEP_FAST[7:0];

  buck_one_ramp #(
    .CW(8)
  ) u_ramp (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .target_i(ramp_target),
    .interval_i(step_interval),
    .immediate_i(fuse_load_i || !enable_next),
    .code_o(ramp_code),
    .falling_o(ramp_falling)
  );

  ////////////////////////////////////////////////////////////////////
  // output next values
  always @* begin
    rvalid_next = rd_i;
    low_power_next = buck_one_control_reg[`BIT_LOW_POWER] && low_power_state;
    forced_pwm_next = buck_one_control_reg[`BIT_FORCED_PWM] ||
      (buck_one_control_reg[`BIT_FORCED_PWM_FALL] && ramp_falling);
  end

  ////////////////////////////////////////////////////////////////////
  // read port
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= 8'h00;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= rvalid_next;
      if (rd_i) begin
        rdata_o <= rdata_next;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // regulator enable
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      buck_enable_o <= 1'b0;
    end else begin
      buck_enable_o <= enable_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // regulator voltage code
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      buck_voltage_o <= `RST_VOLT;
    end else begin
      buck_voltage_o <= ramp_code;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // low power output
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      buck_low_power_o <= 1'b0;
    end else begin
      buck_low_power_o <= low_power_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // forced pwm output
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      buck_forced_pwm_o <= 1'b0;
    end else begin
      buck_forced_pwm_o <= forced_pwm_next;
    end
  end
endmodule

// [sim/buck_one_sva.sv]
// Purpose: port checks, buck one regs
// Assumes: state 0 is run
// Notes: bound below
`timescale 1ns/1ns
module buck_one_sva (
  input wire core_clk_i,
  input wire rstn_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire fuse_load_i,
  input wire [1:0] power_state_i,
  input wire [7:0] rdata_o,
  input wire rvalid_o,
  input wire buck_enable_o,
  input wire buck_low_power_o,
  input wire buck_forced_pwm_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  wire ctl_wr = wr_i && !fuse_load_i && addr_i == 8'h35;
  property p_rv; rd_i |=> rvalid_o; endproperty
  a_rv: assert property (p_rv) else $error("no rvalid");
  property p_rv1; !rd_i |=> !rvalid_o; endproperty
  a_rv1: assert property (p_rv1) else $error("stray rvalid");
  property p_hold; !rd_i |=> $stable(rdata_o); endproperty
  a_hold: assert property (p_hold) else $error("rdata moved");
  property p_unm; rd_i && (addr_i < 8'h32 || addr_i > 8'h35) |=> rdata_o == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  property p_hi; rd_i && (addr_i == 8'h33 || addr_i == 8'h34) |=> rdata_o[7:6] == 2'b00; endproperty
  a_hi: assert property (p_hi) else $error("voltage high bits");
  property p_lp; power_state_i == 2'd0 |=> !buck_low_power_o; endproperty
  a_lp: assert property (p_lp) else $error("low power in run");
  property p_fp; ctl_wr && wdata_i[6] |=> ##1 buck_forced_pwm_o; endproperty
  a_fp: assert property (p_fp) else $error("pwm not forced");
  property p_off; ctl_wr && !wdata_i[0] ##1 power_state_i == 2'd0 |=> !buck_enable_o; endproperty
  a_off: assert property (p_off) else $error("run enable stuck");
endmodule
bind buck_one_mode_control_regs buck_one_sva u_sva (.core_clk_i, .rstn_i, .addr_i, .wdata_i,
  .wr_i, .rd_i, .fuse_load_i, .power_state_i, .rdata_o, .rvalid_o, .buck_enable_o,
  .buck_low_power_o, .buck_forced_pwm_o);

// [sim/host_model.sv]
// Purpose: host side of register port
// Assumes: drives at falling edge
// Notes: idle data inverted
`timescale 1ns/1ns
module host_model (
  input wire core_clk_i,
  input wire [7:0] rdata_i,
  input wire rvalid_i,
  output reg [7:0] addr_o = 8'h00,
  output reg [7:0] wdata_o = 8'h00,
  output reg wr_o = 1'b0,
  output reg rd_o = 1'b0
);
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge core_clk_i);
      addr_o = a;
      wdata_o = d;
      wr_o = 1'b1;
      @(negedge core_clk_i);
      wr_o = 1'b0;
      wdata_o = ~d;
    end
  endtask
  task rd(input [7:0] a, output [7:0] d, output ok);
    begin
      @(negedge core_clk_i);
      addr_o = a;
      rd_o = 1'b1;
      @(negedge core_clk_i);
      rd_o = 1'b0;
      ok = rvalid_i;
      d = rdata_i;
    end
  endtask
endmodule

// [sim/testbench.sv]
// Purpose: register and output tests
// Assumes: short step counts
// Notes: host model drives port
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module testbench;
  reg core_clk_i = 1'b0;
  reg rstn_i = 1'b0;
  reg fuse_load_i = 1'b0;
  reg [1:0] ps = 2'd0;
  reg sel = 1'b0;
  wire [7:0] addr, wdata, rdata;
  wire wr, rd, rvalid, en, lp, fp;
  wire [5:0] volt;
  reg [7:0] d;
  reg ok;
  integer mismatches = 0;
  integer checks_done = 0;
  integer i;
  always #10 core_clk_i = ~core_clk_i;
  host_model host (.core_clk_i(core_clk_i), .rdata_i(rdata), .rvalid_i(rvalid), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  buck_one_mode_control_regs #(.STEP_FAST(4), .STEP_SLOW(8)) uut (.core_clk_i(core_clk_i),
    .rstn_i(rstn_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .fuse_load_i(fuse_load_i), .fuse_run_voltage_i(6'h2a), .fuse_run_enable_i(1'b1),
    .fuse_scaling_rate_i(1'b1), .fuse_buck_one_scaling_select_i(sel), .power_state_i(ps),
    .rdata_o(rdata), .rvalid_o(rvalid), .buck_enable_o(en), .buck_voltage_o(volt),
    .buck_low_power_o(lp), .buck_forced_pwm_o(fp));
  task rc(input [7:0] a, input [7:0] e);
    begin
      host.rd(a, d, ok);
      `CHK("rvalid", 1'b1, ok)
      `CHK("rdata", e, d)
    end
  endtask
  task st(input [1:0] s, input [7:0] c);
    begin
      host.wr(8'h35, c);
      ps = s;
      repeat (600) @(negedge core_clk_i);
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
        $display("Test passed");
      end else begin
        $display("Test failed");
      end
      $finish;
    end
  endtask
  initial begin
    #200000;
    mismatches++;
    end_sim;
  end
  initial begin
    repeat (3) @(negedge core_clk_i);
    rstn_i = 1'b1;
    for (i = 8'h32; i < 8'h37; i++) rc(i[7:0], 8'h00);
    $display("reset test done");
    fuse_load_i = 1'b1;
    @(negedge core_clk_i);
    fuse_load_i = 1'b0;
    rc(8'h32, 8'h2a);
    for (i = 8'h33; i < 8'h35; i++) rc(i[7:0], 8'h2a);
    rc(8'h35, 8'h13);
    $display("fuse test done");
    host.wr(8'h33, 8'hff);
    host.wr(8'h34, 8'hc5);
    host.wr(8'h35, 8'hff);
    host.wr(8'h36, 8'h5a);
    rc(8'h33, 8'h3f);
    rc(8'h34, 8'h05);
    rc(8'h35, 8'h7f);
    rc(8'h36, 8'h00);
    $display("write test done");
    st(2'd0, 8'h41);
    `CHK("outs", 3'b101, {en, lp, fp})
    `CHK("volt", 6'h2a, volt)
    st(2'd0, 8'h0c);
    `CHK("outs", 3'b000, {en, lp, fp})
    st(2'd1, 8'h0c);
    `CHK("outs", 3'b010, {en, lp, fp})
    `CHK("volt", 6'h3f, volt)
    st(2'd2, 8'h0c);
    `CHK("outs", 3'b110, {en, lp, fp})
    `CHK("volt", 6'h05, volt)
    $display("mode test done");
    st(2'd0, 8'h31);
    host.wr(8'h32, 8'h3a);
    repeat (20) @(negedge core_clk_i);
    `CHK("volt", 6'h2c, volt)
    `CHK("fp", 1'b0, fp)
    repeat (200) @(negedge core_clk_i);
    sel = 1'b1;
    host.wr(8'h32, 8'h2a);
    repeat (20) @(negedge core_clk_i);
    `CHK("volt", 6'h36, volt)
    `CHK("fp", 1'b1, fp)
    $display("ramp test done");
    rstn_i = 1'b0;
    @(negedge core_clk_i);
    `CHK("outs", 4'h0, {en, lp, fp, rvalid})
    `CHK("volt", 6'h00, volt)
    rstn_i = 1'b1;
    rc(8'h32, 8'h00);
    rc(8'h35, 8'h00);
    $display("restart test done");
    end_sim;
  end
endmodule
